// >>> rtl/sbe_pkg.sv
// Package for the stream validity bi-phase encoder.
// Assumes a single 20 MHz system clock and synchronous active-high reset.
package sbe_pkg;

  // ==========================================================
  // Sizes and timing
  localparam int SBE_STREAMS = 32;
  localparam int SBE_FIFO_DEPTH = 8;
  localparam int SBE_CLK_HZ = 20000000;
  // Half cells per bit cell; one system clock per half cell
  localparam int SBE_HALVES = 2;
  // Stream clock rates at which per-bit validity should stay off
  localparam int SBE_FAST_RATE_A_MHZ = 64;
  localparam int SBE_FAST_RATE_B_MHZ = 128;

  // ==========================================================
  // Reset values
  localparam logic SBE_RST_CLK = 1'h1;
  localparam logic SBE_RST_VALID = 1'h0;

  // ==========================================================
  // One sample word: data bits, per-bit validity and tick marker
  typedef struct packed {
    logic [SBE_STREAMS-1:0] data;
    logic [SBE_STREAMS-1:0] valid;
    logic tick;
  } sbe_word_t;

  localparam int SBE_WORD_W = $bits(sbe_word_t);

  // Encoder phase within a bit cell
  typedef enum logic [1:0] {SBE_IDLE, SBE_FIRST, SBE_SECOND} sbe_phase_t;

endpackage

// >>> rtl/sbe_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module sbe_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push;
  wire pop;

  // Handshake decode
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// >>> rtl/sbe_encoder.sv
// Bi-phase validity encoder driving reconstructed streams and global valid.
// Assumes sample words arrive synchronous to CLK_SYS from the playback path,
// and that the downstream processor samples data on the rising and
// validity on the falling edge of the output sample clock.
//
// Overview of operation
// (R1) With per-bit validity on, first half carries data, second half validity.
// (R2) Validity half is stable across the falling edge of output sample clock; here the lines switch on that same edge.
// (R3) Invalid bit changes level mid-cell; valid bit holds level whole cell.
// (R4) With per-bit validity off, every stream holds its level the whole cell.
// (R5) Bi-phase doubles toggle rate; warn when enabled at 64 or 128 MHz.
// (R6) Only locally generated validity is encoded; input-side bit validity ignored.
// (R7) Global valid asserts only while all output streams carry valid data.
// (R8) Forwarded input-side global valid may gate the global valid output.
// (R9) Bit invalidation conditions come from user-set mask inputs.
// (R10) One output bit per cell, at most the processor-supplied clock rate.
// (R11) The second-tick bit is always output, keeping its tick relation.
// (R12) Invalid bit drives inverted level in second half; valid repeats it.
`timescale 1ns/100ps
`default_nettype none
module sbe_encoder
  import sbe_pkg::*;
#(
  parameter int STREAMS = sbe_pkg::SBE_STREAMS,
  parameter int FIFO_DEPTH = sbe_pkg::SBE_FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // Sample input from playback path
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic [STREAMS-1:0] IN_DATA,
  input wire logic [STREAMS-1:0] IN_BIT_VALID,
  input wire logic IN_SECOND_TICK,
  // User configuration
  input wire logic CFG_BIPHASE_EN,
  input wire logic CFG_USE_INPUT_VALID,
  input wire logic [STREAMS-1:0] CFG_STREAM_INVALID,
  input wire logic CFG_FAST_CLOCK,
  input wire logic INPUT_GLOBAL_VALID,
  // Downstream processor side
  output logic OUTPUT_SAMPLE_CLOCK,
  output logic [STREAMS-1:0] RECONSTRUCTED_STREAM,
  output logic OUTPUT_GLOBAL_VALID,
  output logic OUTPUT_SECOND_TICK,
  output logic RATE_WARNING
);
  import sbe_pkg::*;

  // ==========================================================
  // Buffering
  localparam int WW = 2 * STREAMS + 1;

  logic [WW-1:0] fifo_in;
  logic [WW-1:0] fifo_out;
  logic fifo_valid;
  wire fifo_pop;

  // (R6) Input validity bits are not forwarded
  assign fifo_in = {IN_DATA, {STREAMS{1'b1}} & ~CFG_STREAM_INVALID, IN_SECOND_TICK};

  sbe_fifo #(.WIDTH(WW), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .clk(CLK_SYS),
    .srst(SRST),
    .in_valid(IN_VALID),
    .in_ready(IN_READY),
    .in_data(fifo_in),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  // ==========================================================
  // Cell sequencing
  sbe_phase_t phase_q;
  sbe_phase_t phase_d;
  logic [STREAMS-1:0] data_q;
  logic [STREAMS-1:0] bitok_q;
  logic tick_q;
  logic [STREAMS-1:0] stream_q;
  logic [STREAMS-1:0] stream_d;
  logic clk_q;
  logic clk_d;
  logic gvalid_q;
  logic gvalid_d;
  logic tick_out_q;
  logic warn_q;
  wire [STREAMS-1:0] w_data;
  wire [STREAMS-1:0] w_ok;
  wire w_tick;
  wire all_ok;
  wire start_cell;

  assign w_data = fifo_out[WW-1 -: STREAMS];
  // (R9) User mask decides bit invalidation
  assign w_ok = fifo_out[STREAMS:1];
  assign w_tick = fifo_out[0];
  // (R10) One word per two-clock cell
  assign start_cell = (phase_q != SBE_FIRST) && fifo_valid;
  assign fifo_pop = start_cell;
  // (R7) All streams valid
  assign all_ok = &bitok_q;

  // ==========================================================
  // Second-half level, one stream at a time
  wire [STREAMS-1:0] second_lvl;

  genvar gi;
  generate
    for (gi = 0; gi < STREAMS; gi++)
    begin : g_half
      // (R12) (R3) Invert on invalid, hold on valid
      // (R4) Bi-phase off holds the whole cell
      assign second_lvl[gi] = CFG_BIPHASE_EN ? (data_q[gi] ^ ~bitok_q[gi]) : data_q[gi];
    end
  endgenerate

  // Input-side valid term, shared by both halves of a cell
  function automatic logic input_gate(input logic use_iv, input logic igv);
    input_gate = !use_iv || igv;
  endfunction

  // Next phase
  always_comb
  begin
    case (phase_q)
      SBE_IDLE: phase_d = fifo_valid ? SBE_FIRST : SBE_IDLE;
      SBE_FIRST: phase_d = SBE_SECOND;
      SBE_SECOND: phase_d = fifo_valid ? SBE_FIRST : SBE_IDLE;
      default: phase_d = SBE_IDLE;
    endcase
  end

  // Output line levels per half cell
  always_comb
  begin
    stream_d = stream_q;
    clk_d = SBE_RST_CLK;
    gvalid_d = gvalid_q;
    if (start_cell)
    begin
      // (R1) Data in first half
      stream_d = w_data;
      clk_d = 1'b1;
      // (R7) (R8) Global valid from streams and input side
      gvalid_d = (&w_ok) && input_gate(CFG_USE_INPUT_VALID, INPUT_GLOBAL_VALID);
    end
    else if (phase_q == SBE_FIRST)
    begin
      // (R12) (R3) (R4) Second-half level per stream
      stream_d = second_lvl;
      // (R2) Clock falls on the same edge that puts the validity half on the lines
      clk_d = 1'b0;
      gvalid_d = all_ok && input_gate(CFG_USE_INPUT_VALID, INPUT_GLOBAL_VALID);
    end
  end

  // Phase, line levels, output clock and global valid
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      phase_q <= SBE_IDLE;
      stream_q <= '0;
      clk_q <= SBE_RST_CLK;
      gvalid_q <= SBE_RST_VALID;
    end
    else
    begin
      phase_q <= phase_d;
      stream_q <= stream_d;
      clk_q <= clk_d;
      gvalid_q <= gvalid_d;
    end
  end

  // Word kept for the second half of its cell
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      data_q <= '0;
      bitok_q <= '1;
      tick_q <= 1'b0;
    end
    else if (start_cell)
    begin
      data_q <= w_data;
      bitok_q <= w_ok;
      tick_q <= w_tick;
    end
  end

  // (R11) Tick bit always emitted, aligned to cell
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      tick_out_q <= 1'b0;
    end
    else if (start_cell)
    begin
      tick_out_q <= w_tick;
    end
    else if (phase_q == SBE_FIRST)
    begin
      tick_out_q <= tick_q;
    end
    else
    begin
      tick_out_q <= 1'b0;
    end
  end

  // (R5) Flag bi-phase at high stream rates
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      warn_q <= 1'b0;
    end
    else
    begin
      warn_q <= CFG_BIPHASE_EN && CFG_FAST_CLOCK;
    end
  end

  // Outputs straight from flip-flops
  assign OUTPUT_SAMPLE_CLOCK = clk_q;
  assign RECONSTRUCTED_STREAM = stream_q;
  assign OUTPUT_GLOBAL_VALID = gvalid_q;
  assign OUTPUT_SECOND_TICK = tick_out_q;
  assign RATE_WARNING = warn_q;
endmodule
`default_nettype wire

// >>> testbench/sbe_chk.sv
// Port checker for the encoder.
// Assumes config is held steady per test.
`timescale 1ns/100ps
`default_nettype none
module sbe_chk
  import sbe_pkg::*;
#(parameter int STREAMS = SBE_STREAMS)
(
  // Clock, reset and config
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic CFG_BIPHASE_EN,
  input wire logic CFG_FAST_CLOCK,
  input wire logic CFG_USE_INPUT_VALID,
  input wire logic INPUT_GLOBAL_VALID,
  input wire logic [STREAMS-1:0] CFG_STREAM_INVALID,
  // Outputs
  input wire logic OUTPUT_SAMPLE_CLOCK,
  input wire logic [STREAMS-1:0] RECONSTRUCTED_STREAM,
  input wire logic OUTPUT_GLOBAL_VALID,
  input wire logic OUTPUT_SECOND_TICK,
  input wire logic RATE_WARNING
);
  wire oc = OUTPUT_SAMPLE_CLOCK;
  wire [STREAMS-1:0] ln = RECONSTRUCTED_STREAM;
  logic [4:0] calm_q;
  wire calm = calm_q == 5'h1F;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  // Counts cycles of steady invalid mask and bi-phase enable, saturating at 31
  always_ff @(posedge CLK_SYS)
    if (SRST || !$stable({CFG_STREAM_INVALID, CFG_BIPHASE_EN}))
      calm_q <= 5'h0;
    else if (!calm)
      calm_q <= calm_q + 5'h1;
  a_warn_delay: assert property (!$past(SRST) |->
    RATE_WARNING == $past(CFG_BIPHASE_EN && CFG_FAST_CLOCK)) else $error("warn");
  a_half_one: assert property ($fell(oc) |=> oc) else $error("half");
  a_off_hold: assert property (calm && !CFG_BIPHASE_EN && $fell(oc) |-> $stable(ln))
    else $error("off");
  a_bi_code: assert property (calm && CFG_BIPHASE_EN && $fell(oc) |->
    ln == ($past(ln) ^ CFG_STREAM_INVALID)) else $error("code");
  a_gv_streams: assert property (calm && |CFG_STREAM_INVALID && !oc |->
    !OUTPUT_GLOBAL_VALID) else $error("gv");
  a_gv_input: assert property ($fell(oc) && $past(CFG_USE_INPUT_VALID) &&
    !$past(INPUT_GLOBAL_VALID) |-> !OUTPUT_GLOBAL_VALID) else $error("igv");
  a_tick_cell: assert property ($rose(OUTPUT_SECOND_TICK) |->
    oc ##1 (!oc && OUTPUT_SECOND_TICK)) else $error("tick");
  a_tick_end: assert property ($fell(OUTPUT_SECOND_TICK) |-> oc) else $error("tend");
  c_invalid: cover property ($fell(oc) && |CFG_STREAM_INVALID);
  c_tick: cover property ($rose(OUTPUT_SECOND_TICK));
  c_warn: cover property ($rose(RATE_WARNING));
endmodule
bind sbe_encoder sbe_chk #(.STREAMS(STREAMS)) u_sbe_chk (.CLK_SYS, .SRST, .CFG_BIPHASE_EN,
  .CFG_FAST_CLOCK, .CFG_USE_INPUT_VALID, .INPUT_GLOBAL_VALID, .CFG_STREAM_INVALID,
  .OUTPUT_SAMPLE_CLOCK, .RECONSTRUCTED_STREAM, .OUTPUT_GLOBAL_VALID, .OUTPUT_SECOND_TICK,
  .RATE_WARNING);
`default_nettype wire

// >>> testbench/sbe_sink.sv
// Downstream processor model, one cell per two clocks.
// Assumes registered encoder outputs.
`timescale 1ns/100ps
`default_nettype none
module sbe_sink
  import sbe_pkg::*;
(
  // Encoder side
  input wire logic clk,
  input wire logic osc,
  input wire logic [SBE_STREAMS-1:0] line,
  input wire logic gv,
  input wire logic tk,
  // Decoded cell
  output logic [SBE_STREAMS-1:0] data_q,
  output logic [SBE_STREAMS-1:0] ok_q,
  output logic gv_q,
  output logic tk_q,
  output int cells_q
);
  logic [SBE_STREAMS-1:0] first_q;
  initial cells_q = 0;
  always @(posedge clk)
    if (osc)
      first_q <= line;
    else
    begin
      data_q <= first_q;
      ok_q <= ~(line ^ first_q);
      gv_q <= gv;
      tk_q <= tk;
      cells_q <= cells_q + 1;
    end
endmodule
`default_nettype wire

// >>> testbench/tb_stream_validity_biphase_encoder.sv
// Bench for the encoder with a processor model.
// Assumes the checker is bound to the encoder.
`timescale 1ns/100ps
`default_nettype none
module tb_stream_validity_biphase_encoder;
  import sbe_pkg::*;
  logic clk = 1'h0, srst = 1'h1, in_valid = 1'h0, tick = 1'h0, bip = 1'h0, use_iv = 1'h0;
  logic igv = 1'h1, fast = 1'h1, in_ready, osc, ogv, warn, s_gv, otick, s_tick;
  logic [31:0] din = 32'h0, inv = 32'h0, rs, s_data, s_ok;
  int s_cells, stalls = 0, err_count = 0, total_checks = 0;
  // System clock
  always #25 clk = ~clk;
  sbe_encoder u_sbe_encoder (.CLK_SYS(clk), .SRST(srst), .IN_VALID(in_valid),
    .IN_READY(in_ready), .IN_DATA(din), .IN_BIT_VALID(32'h0), .IN_SECOND_TICK(tick),
    .CFG_BIPHASE_EN(bip), .CFG_USE_INPUT_VALID(use_iv), .CFG_STREAM_INVALID(inv),
    .CFG_FAST_CLOCK(fast), .INPUT_GLOBAL_VALID(igv), .OUTPUT_SAMPLE_CLOCK(osc),
    .RECONSTRUCTED_STREAM(rs), .OUTPUT_GLOBAL_VALID(ogv), .OUTPUT_SECOND_TICK(otick),
    .RATE_WARNING(warn));
  sbe_sink u_sbe_sink (.clk(clk), .osc(osc), .line(rs), .gv(ogv), .tk(otick),
    .data_q(s_data), .ok_q(s_ok), .gv_q(s_gv), .tk_q(s_tick), .cells_q(s_cells));
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
  begin
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  end
  endtask
  task automatic conclude;
  begin
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task automatic hang;
  begin
    err_count++;
    conclude();
  end
  endtask
  // Offers a word until taken; counts refused cycles
  task automatic send(input logic [31:0] d);
  begin
    int n;
    in_valid = 1'h1;
    din = d;
    for (n = 0; !in_ready; n++)
    begin
      if (n == 40) hang();
      @(negedge clk);
    end
    stalls += n;
    @(negedge clk);
  end
  endtask
  // Stops offering and waits until the decoded cell count reaches c
  task automatic drain(input int c);
  begin
    int n;
    in_valid = 1'h0;
    for (n = 0; s_cells < c; n++)
    begin
      if (n == 60) hang();
      @(negedge clk);
    end
  end
  endtask
  task automatic setup(input logic b, input logic [31:0] m, input logic u);
  begin
    bip = b;
    inv = m;
    use_iv = u;
    repeat (32) @(negedge clk);
  end
  endtask
  task automatic sc_plain;
  begin
    setup(1'h0, 32'h0, 1'h0);
    tick = 1'h1;
    send(32'hA5C3_0F01);
    drain(s_cells + 1);
    tick = 1'h0;
    chk("data", s_data, 32'hA5C3_0F01);
    chk("ok", s_ok, 32'hFFFF_FFFF);
    chk("gv", s_gv, 1'h1);
    chk("tick", s_tick, 1'h1);
    chk("warn", warn, 1'h0);
  end
  endtask
  task automatic sc_biph;
  begin
    setup(1'h1, 32'h8000_FF01, 1'h0);
    send(32'h1234_5678);
    drain(s_cells + 1);
    chk("data", s_data, 32'h1234_5678);
    chk("ok", s_ok, 32'h7FFF_00FE);
    chk("gv", s_gv, 1'h0);
    chk("tick", s_tick, 1'h0);
    chk("warn", warn, 1'h1);
  end
  endtask
  task automatic sc_input;
  begin
    fast = 1'h0;
    setup(1'h1, 32'h0, 1'h1);
    for (int i = 0; i < 2; i++)
    begin
      igv = i[0];
      send(32'h0);
      drain(s_cells + 1);
      chk("igv", s_gv, i[0]);
    end
    chk("warn", warn, 1'h0);
  end
  endtask
  task automatic sc_fill;
  begin
    int c;
    setup(1'h0, 32'h0, 1'h0);
    c = s_cells;
    for (int i = 1; i <= 20; i++)
      send(i);
    drain(c + 20);
    chk("refused", stalls != 0, 1'h1);
    chk("last", s_data, 32'h14);
  end
  endtask
  // Reset, then each scenario in turn
  initial
  begin
    repeat (16) @(negedge clk);
    srst = 1'h0;
    chk("reset", {osc, ogv, warn}, 32'h4);
    chk("lines", rs, 32'h0);
    sc_plain();
    sc_biph();
    sc_input();
    sc_fill();
    conclude();
  end
endmodule
`default_nettype wire
